// *** src/odcc_decoder.sv ***
// Config command decoder: parses command bytes, holds scan/drive options.
// Assumes command bytes arrive as writes to the CMD offset (select low),
// argument bytes too; writes to the DATA offset are ignored; reads return one cycle later.
//
// Function
// - A0 plus argument; bit4 clear no remap
// - Remap bit4 set reverses row lines
// - Remap bit6 enables odd/even row split
// - A1 argument loads start line, reset zero
// - A2 argument sets vertical offset, reset zero
// - A4..A7 select mode, A7 inverts
// - A5 all on level 15, A6 off
// - A8 argument sets mux ratio, reset 4F
// - AD bit0 enables converter, default on
// - AD bit1 enables deselect generator, default on
// - AE sleep display off, AF display on
// - BE sets deselect level, bit5 full
// - BC sets precharge level, reset 18
// - Precharge top bit ties, 001 full
// - B1 low nibble phase one, reset 3
// - B1 high nibble phase two, reset 5
// - B2 sets clocks per row, reset 25
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "odcc_map.svh"

module odcc_decoder (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    // Row scan options
    output logic             rowRemap,
    output logic             rowSplit,
    output logic      [6:0]  startLine,
    output logic      [6:0]  vertOffset,
    output logic      [6:0]  muxRatio,
    // Display mode
    output logic             pixelForceOn,
    output logic             pixelForceOff,
    output logic             pixelInvert,
    output logic      [3:0]  forcedGrayLevel,
    output logic             displayOn,
    output logic             sleepMode,
    // Power and levels
    output logic             dcdcEnable,
    output logic             deselGenEnable,
    output logic      [5:0]  rowDeselectLevel,
    output logic             deselFullRef,
    output logic      [7:0]  prechargeLevel,
    output logic             prechargeTiedDesel,
    output logic             prechargeFullRef,
    // Timing
    output logic      [3:0]  phaseOneLength,
    output logic      [3:0]  phaseTwoLength,
    output logic      [7:0]  rowPeriod
);

    // ------------------------------------------------------------------
    // Byte stream
    // ------------------------------------------------------------------
    logic       cmdWr;
    logic [7:0] cmdByte;
    assign cmdWr   = regWrEn && (regAddr == `ODCC_OFS_CMD);
    assign cmdByte = regWrData[7:0];

    // ------------------------------------------------------------------
    // Parser
    // ------------------------------------------------------------------
    odcc_pkg::odcc_state_e state_r;
    odcc_pkg::odcc_state_e state_nxt;
    logic [7:0] pendOp_r;
    logic [7:0] pendOp_nxt;
    logic [3:0] skipCnt_r;
    logic [3:0] skipCnt_nxt;
    logic       argLoad;
    logic       opTakesArg;
    logic [3:0] opSkip;
    logic       modeLoad;
    logic       dispLoad;

    always_comb begin
        case (cmdByte)
            `ODCC_OP_REMAP, `ODCC_OP_START, `ODCC_OP_OFFSET,
            `ODCC_OP_MUX, `ODCC_OP_MASTER, `ODCC_OP_DESEL,
            `ODCC_OP_PRECH, `ODCC_OP_PHASE, `ODCC_OP_ROWPER: begin
                opTakesArg = 1'b1;
            end
            default: begin
                opTakesArg = 1'b0;
            end
        endcase
        case (cmdByte)
            `ODCC_OP_COLADDR, `ODCC_OP_ROWADDR: opSkip = `ODCC_SKIP_TWO;
            `ODCC_OP_CONTRAST, `ODCC_OP_CLKDIV,
            `ODCC_OP_BIAS: opSkip = `ODCC_SKIP_ONE;
            `ODCC_OP_GRAYTAB: opSkip = `ODCC_SKIP_EIGHT;
            default: opSkip = 4'h0;
        endcase
    end

    always_comb begin
        state_nxt   = state_r;
        pendOp_nxt  = pendOp_r;
        skipCnt_nxt = skipCnt_r;
        argLoad     = 1'b0;
        modeLoad    = 1'b0;
        dispLoad    = 1'b0;
        if (cmdWr) begin
            case (state_r)
                odcc_pkg::ODCC_IDLE: begin
                    if (opTakesArg) begin
                        pendOp_nxt = cmdByte;
                        state_nxt  = odcc_pkg::ODCC_ARG;
                    end else if (opSkip != 4'h0) begin
                        skipCnt_nxt = opSkip;
                        state_nxt   = odcc_pkg::ODCC_SKIP;
                    end else if (cmdByte >= `ODCC_OP_MODE_LO &&
                                 cmdByte <= `ODCC_OP_MODE_HI) begin
                        modeLoad = 1'b1;
                    end else if (cmdByte == `ODCC_OP_SLEEP ||
                                 cmdByte == `ODCC_OP_WAKE) begin
                        dispLoad = 1'b1;
                    end
                end
                odcc_pkg::ODCC_ARG: begin
                    argLoad   = 1'b1;
                    state_nxt = odcc_pkg::ODCC_IDLE;
                end
                odcc_pkg::ODCC_SKIP: begin
                    skipCnt_nxt = skipCnt_r - 4'h1;
                    if (skipCnt_r == 4'h1) begin
                        state_nxt = odcc_pkg::ODCC_IDLE;
                    end
                end
                default: begin
                    state_nxt = odcc_pkg::ODCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r   <= odcc_pkg::ODCC_IDLE;
            pendOp_r  <= 8'h00;
            skipCnt_r <= 4'h0;
        end else begin
            state_r   <= state_nxt;
            pendOp_r  <= pendOp_nxt;
            skipCnt_r <= skipCnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    // Fields hold between loads
    logic [6:0] remap;
    logic [1:0] mode;
    logic [1:0] master;
    logic       dispOn;

    odcc_field #(.W(7), .RST(`ODCC_RST_REMAP)) uRemap (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_REMAP),
        .din(cmdByte[6:0]), .q(remap));
    odcc_field #(.W(7), .RST(`ODCC_RST_START)) uStart (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_START),
        .din(cmdByte[6:0]), .q(startLine));
    odcc_field #(.W(7), .RST(`ODCC_RST_OFFSET)) uOffset (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_OFFSET),
        .din(cmdByte[6:0]), .q(vertOffset));
    odcc_field #(.W(2), .RST(`ODCC_RST_MODE)) uMode (
        .clock(clock), .rst(rst), .load(modeLoad),
        .din(cmdByte[1:0]), .q(mode));
    odcc_field #(.W(7), .RST(`ODCC_RST_MUX)) uMux (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_MUX),
        .din(cmdByte[6:0]), .q(muxRatio));
    odcc_field #(.W(2), .RST(`ODCC_RST_MASTER)) uMaster (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_MASTER),
        .din(cmdByte[1:0]), .q(master));
    odcc_field #(.W(1), .RST(1'b0)) uDisp (
        .clock(clock), .rst(rst), .load(dispLoad),
        .din(cmdByte[0]), .q(dispOn));
    odcc_field #(.W(6), .RST(`ODCC_RST_DESEL)) uDesel (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_DESEL),
        .din(cmdByte[5:0]), .q(rowDeselectLevel));
    odcc_field #(.W(8), .RST(`ODCC_RST_PRECH)) uPrech (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_PRECH),
        .din(cmdByte), .q(prechargeLevel));
    odcc_field #(.W(4), .RST(`ODCC_RST_PHASE1)) uPh1 (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_PHASE),
        .din(cmdByte[3:0]), .q(phaseOneLength));
    odcc_field #(.W(4), .RST(`ODCC_RST_PHASE2)) uPh2 (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_PHASE),
        .din(cmdByte[7:4]), .q(phaseTwoLength));
    odcc_field #(.W(8), .RST(`ODCC_RST_ROWPER)) uRowPer (
        .clock(clock), .rst(rst),
        .load(argLoad && pendOp_r == `ODCC_OP_ROWPER),
        .din(cmdByte), .q(rowPeriod));

    // ------------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------------
    // Row line reversal
    assign rowRemap = remap[`ODCC_REMAP_ROW_BIT];
    assign rowSplit = remap[`ODCC_REMAP_SPLIT_BIT];
    assign pixelForceOn    = mode == 2'(odcc_pkg::ODCC_MODE_ALL_ON);
    assign pixelForceOff   = mode == 2'(odcc_pkg::ODCC_MODE_ALL_OFF);
    assign pixelInvert     = mode == 2'(odcc_pkg::ODCC_MODE_INVERT);
    assign forcedGrayLevel = pixelForceOn ? `ODCC_GRAY_FULL : 4'h0;
    assign displayOn = dispOn;
    assign sleepMode = !dispOn;
    assign dcdcEnable     = master[`ODCC_MASTER_DCDC_BIT];
    assign deselGenEnable = master[`ODCC_MASTER_DESEL_BIT];
    assign deselFullRef   = rowDeselectLevel[`ODCC_DESEL_FULL_BIT];
    assign prechargeTiedDesel = prechargeLevel[`ODCC_PRECH_TIE_BIT];
    assign prechargeFullRef   = prechargeLevel[7:5] == 3'h1;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;

    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (regRdEn) begin
            case (regAddr)
                `ODCC_OFS_REMAP:   rdData_nxt = {25'h0, remap};
                `ODCC_OFS_START:   rdData_nxt = {25'h0, startLine};
                `ODCC_OFS_OFFSET:  rdData_nxt = {25'h0, vertOffset};
                `ODCC_OFS_MODE:    rdData_nxt = {30'h0, mode};
                `ODCC_OFS_MUX:     rdData_nxt = {25'h0, muxRatio};
                `ODCC_OFS_MASTER:  rdData_nxt = {30'h0, master};
                `ODCC_OFS_DISPLAY: rdData_nxt = {31'h0, dispOn};
                `ODCC_OFS_DESEL:   rdData_nxt = {26'h0, rowDeselectLevel};
                `ODCC_OFS_PRECH:   rdData_nxt = {24'h0, prechargeLevel};
                `ODCC_OFS_PHASE:
                    rdData_nxt = {24'h0, phaseTwoLength, phaseOneLength};
                `ODCC_OFS_ROWPER:  rdData_nxt = {24'h0, rowPeriod};
                `ODCC_OFS_STATUS:
                    rdData_nxt = {16'h0, pendOp_r, skipCnt_r, 2'h0, state_r};
                default:           rdData_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_r <= 32'h0000_0000;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    remap_load_a: assert property (@(posedge clock) disable iff (rst)
        argLoad && pendOp_r == `ODCC_OP_REMAP |=> remap == $past(cmdByte[6:0]))
        else $error("remap argument not stored");
    row_reverse_a: assert property (@(posedge clock) disable iff (rst)
        argLoad && pendOp_r == `ODCC_OP_REMAP |=> rowRemap == $past(cmdByte[4])
        && rowSplit == $past(cmdByte[6]))
        else $error("row remap flags wrong");
    start_line_a: assert property (@(posedge clock) disable iff (rst)
        argLoad && pendOp_r == `ODCC_OP_START
        |=> startLine == $past(cmdByte[6:0]))
        else $error("start line not loaded");
    mode_select_a: assert property (@(posedge clock) disable iff (rst)
        cmdWr && state_r == odcc_pkg::ODCC_IDLE && cmdByte == 8'ha7
        |=> pixelInvert && !pixelForceOn && !pixelForceOff)
        else $error("inverse mode not entered");
    force_on_a: assert property (@(posedge clock) disable iff (rst)
        cmdWr && state_r == odcc_pkg::ODCC_IDLE && cmdByte == 8'ha5
        |=> pixelForceOn && forcedGrayLevel == 4'hf && !pixelForceOff)
        else $error("forced on level wrong");
    reset_defaults_a: assert property (@(posedge clock)
        rst |=> muxRatio == 7'h4f && rowPeriod == 8'h25 && master == 2'h3
        && phaseOneLength == 4'h3 && phaseTwoLength == 4'h5 && !displayOn)
        else $error("reset defaults wrong");
    sleep_wake_a: assert property (@(posedge clock) disable iff (rst)
        cmdWr && state_r == odcc_pkg::ODCC_IDLE && cmdByte == 8'haf
        ##1 !cmdWr |-> displayOn && !sleepMode)
        else $error("display not woken");
    arg_order_a: assert property (@(posedge clock) disable iff (rst)
        cmdWr && state_r == odcc_pkg::ODCC_IDLE && opTakesArg
        |=> state_r == odcc_pkg::ODCC_ARG && !modeLoad && !dispLoad)
        else $error("argument byte not awaited");
    hold_value_a: assert property (@(posedge clock) disable iff (rst)
        !cmdWr && !rst |=> $stable(rowPeriod) && $stable(prechargeLevel)
        && $stable(mode) && $stable(remap) && $stable(vertOffset))
        else $error("config changed without command");

endmodule // odcc_decoder

// *** src/odcc_field.sv ***
// One configuration field: loads on request, otherwise holds.
// Assumes a synchronous active-high reset restoring the default.
`timescale 1ns/1ps

module odcc_field #(
    parameter int         W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Load port
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q
);

    logic [W-1:0] val_r;
    logic [W-1:0] val_nxt;

    always_comb begin
        val_nxt = val_r;
        if (load) begin
            val_nxt = din;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            val_r <= RST;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign q = val_r;

endmodule // odcc_field

// *** src/odcc_map.svh ***
// Offsets, field positions, reset values and opcodes of the config decoder.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef ODCC_MAP_SVH
`define ODCC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ODCC_OFS_CMD      8'h00
`define ODCC_OFS_DATA     8'h04
`define ODCC_OFS_REMAP    8'h08
`define ODCC_OFS_START    8'h0c
`define ODCC_OFS_OFFSET   8'h10
`define ODCC_OFS_MODE     8'h14
`define ODCC_OFS_MUX      8'h18
`define ODCC_OFS_MASTER   8'h1c
`define ODCC_OFS_DISPLAY  8'h20
`define ODCC_OFS_DESEL    8'h24
`define ODCC_OFS_PRECH    8'h28
`define ODCC_OFS_PHASE    8'h2c
`define ODCC_OFS_ROWPER   8'h30
`define ODCC_OFS_STATUS   8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ODCC_REMAP_ROW_BIT    4
`define ODCC_REMAP_SPLIT_BIT  6
`define ODCC_MASTER_DCDC_BIT  0
`define ODCC_MASTER_DESEL_BIT 1
`define ODCC_DESEL_FULL_BIT   5
`define ODCC_PRECH_TIE_BIT    7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ODCC_RST_REMAP    7'h00
`define ODCC_RST_START    7'h00
`define ODCC_RST_OFFSET   7'h00
`define ODCC_RST_MODE     2'h0
`define ODCC_RST_MUX      7'h4f
`define ODCC_RST_MASTER   2'h3
`define ODCC_RST_DESEL    6'h11
`define ODCC_RST_PRECH    8'h18
`define ODCC_RST_PHASE1   4'h3
`define ODCC_RST_PHASE2   4'h5
`define ODCC_RST_ROWPER   8'h25

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define ODCC_OP_REMAP     8'ha0
`define ODCC_OP_START     8'ha1
`define ODCC_OP_OFFSET    8'ha2
`define ODCC_OP_MODE_LO   8'ha4
`define ODCC_OP_MODE_HI   8'ha7
`define ODCC_OP_MUX       8'ha8
`define ODCC_OP_MASTER    8'had
`define ODCC_OP_SLEEP     8'hae
`define ODCC_OP_WAKE      8'haf
`define ODCC_OP_DESEL     8'hbe
`define ODCC_OP_PRECH     8'hbc
`define ODCC_OP_PHASE     8'hb1
`define ODCC_OP_ROWPER    8'hb2
// Foreign opcodes whose arguments are skipped
`define ODCC_OP_COLADDR   8'h15
`define ODCC_OP_ROWADDR   8'h75
`define ODCC_OP_CONTRAST  8'h81
`define ODCC_OP_CLKDIV    8'hb3
`define ODCC_OP_GRAYTAB   8'hb8
`define ODCC_OP_BIAS      8'hcf
`define ODCC_SKIP_TWO     4'h2
`define ODCC_SKIP_ONE     4'h1
`define ODCC_SKIP_EIGHT   4'h8

`define ODCC_GRAY_FULL    4'hf

`endif

// *** src/odcc_pkg.sv ***
// Types shared by the config decoder files.
// Assumes odcc_map.svh carries all numeric constants.
package odcc_pkg;

    // Parser states
    typedef enum logic [1:0] {
        ODCC_IDLE,
        ODCC_ARG,
        ODCC_SKIP
    } odcc_state_e;

    // Display modes in opcode order
    typedef enum logic [1:0] {
        ODCC_MODE_NORMAL,
        ODCC_MODE_ALL_ON,
        ODCC_MODE_ALL_OFF,
        ODCC_MODE_INVERT
    } odcc_mode_e;

endpackage

// *** tb/odcc_host.sv ***
// Host model: issues command bytes and reads over the register port.
// Assumes one clock; strobes are driven right after a rising edge.
`timescale 1ns/1ps
`include "odcc_map.svh"

module odcc_host (
    // Clock
    input  wire logic        clock,
    // Register port, master side
    output logic      [7:0]  regAddr,
    output logic      [31:0] regWrData,
    output logic             regWrEn,
    output logic             regRdEn,
    input  wire logic [31:0] regRdData
);
    initial begin
        regAddr = 8'hff;
        regWrData = 32'h0000_0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Released data lines show the inverse and the address goes to ff, so stale data never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        regAddr <= a;
        regWrData <= {a, a, a, b};
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
        regAddr <= 8'hff;
        regWrData <= ~{a, a, a, b};
    endtask

    task automatic cmd(input logic [7:0] b);
        wr(`ODCC_OFS_CMD, b);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        regAddr <= 8'hff;
        @(posedge clock);
        d = regRdData;
    endtask
endmodule // odcc_host

// *** tb/tb_oled_display_config_commands.sv ***
// Bench for the config decoder: table of commands, then reset and
// argument-parsing corner cases. Assumes the host model drives the bus.
`timescale 1ns/1ps
`include "odcc_map.svh"

module tb_oled_display_config_commands;
    typedef struct {
        logic [7:0]  op;
        logic        hasArg;
        logic [7:0]  arg;
        logic [7:0]  ofs;
        logic [31:0] exp;
    } odcc_row_s;

    logic        clock;
    logic        rst;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [31:0] regRdData;
    logic        rowRemap, rowSplit, pixelForceOn, pixelForceOff;
    logic        pixelInvert, displayOn, sleepMode, dcdcEnable;
    logic        deselGenEnable, deselFullRef, prechargeTiedDesel;
    logic        prechargeFullRef;
    logic [6:0]  startLine, vertOffset, muxRatio;
    logic [3:0]  forcedGrayLevel, phaseOneLength, phaseTwoLength;
    logic [5:0]  rowDeselectLevel;
    logic [7:0]  prechargeLevel, rowPeriod;
    logic [31:0] d;
    int          errTotal = 0;
    int          checked = 0;

    // ------------------------------------------------------------------
    // Command table, last write of each kind except mode also seen at the ports
    // ------------------------------------------------------------------
    odcc_row_s rows [16] = '{
        '{8'ha0, 1, 8'h20, `ODCC_OFS_REMAP, 32'h20},
        '{8'ha0, 1, 8'h50, `ODCC_OFS_REMAP, 32'h50},
        '{8'ha1, 1, 8'h7f, `ODCC_OFS_START, 32'h7f},
        '{8'ha2, 1, 8'h4f, `ODCC_OFS_OFFSET, 32'h4f},
        '{8'ha8, 1, 8'h0f, `ODCC_OFS_MUX, 32'h0f},
        '{8'had, 1, 8'h02, `ODCC_OFS_MASTER, 32'h2},
        '{8'had, 1, 8'h01, `ODCC_OFS_MASTER, 32'h1},
        '{8'haf, 0, 8'h00, `ODCC_OFS_DISPLAY, 32'h1},
        '{8'hae, 0, 8'h00, `ODCC_OFS_DISPLAY, 32'h0},
        '{8'hbe, 1, 8'h3f, `ODCC_OFS_DESEL, 32'h3f},
        '{8'hbc, 1, 8'h3f, `ODCC_OFS_PRECH, 32'h3f},
        '{8'hbc, 1, 8'h80, `ODCC_OFS_PRECH, 32'h80},
        '{8'hb1, 1, 8'hf1, `ODCC_OFS_PHASE, 32'hf1},
        '{8'hb2, 1, 8'h9e, `ODCC_OFS_ROWPER, 32'h9e},
        '{8'ha7, 0, 8'h00, `ODCC_OFS_MODE, 32'h3},
        '{8'ha4, 0, 8'h00, `ODCC_OFS_MODE, 32'h0}
    };

    odcc_host u_host (
        .clock     (clock),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrEn   (regWrEn),
        .regRdEn   (regRdEn),
        .regRdData (regRdData)
    );

    odcc_decoder u_dut (
        .clock(clock), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .rowRemap(rowRemap), .rowSplit(rowSplit),
        .startLine(startLine), .vertOffset(vertOffset),
        .muxRatio(muxRatio), .pixelForceOn(pixelForceOn),
        .pixelForceOff(pixelForceOff), .pixelInvert(pixelInvert),
        .forcedGrayLevel(forcedGrayLevel), .displayOn(displayOn),
        .sleepMode(sleepMode), .dcdcEnable(dcdcEnable),
        .deselGenEnable(deselGenEnable),
        .rowDeselectLevel(rowDeselectLevel), .deselFullRef(deselFullRef),
        .prechargeLevel(prechargeLevel),
        .prechargeTiedDesel(prechargeTiedDesel),
        .prechargeFullRef(prechargeFullRef),
        .phaseOneLength(phaseOneLength), .phaseTwoLength(phaseTwoLength),
        .rowPeriod(rowPeriod)
    );

    // ------------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrapUp();
        if (errTotal == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: the bus never waits, so this only trips on a stuck run
    initial begin
        repeat (20000) @(posedge clock);
        errTotal++;
        wrapUp();
    end

    task automatic ports(input logic [31:0] exp);
        check(32'({rowRemap, rowSplit, dcdcEnable, deselGenEnable,
                   deselFullRef, prechargeTiedDesel, prechargeFullRef,
                   displayOn, sleepMode}), exp);
    endtask

    initial begin
        rst = 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            u_host.cmd(rows[i].op);
            if (rows[i].hasArg)
                u_host.cmd(rows[i].arg);
            u_host.rd(rows[i].ofs, d);
            check(d, rows[i].exp);
        end
        ports(32'b111011001);
        check(32'({startLine, vertOffset, muxRatio, rowPeriod}),
              32'({7'h7f, 7'h4f, 7'h0f, 8'h9e}));
        check(32'({phaseTwoLength, phaseOneLength, rowDeselectLevel,
                   prechargeLevel}),
              32'({4'hf, 4'h1, 6'h3f, 8'h80}));
        u_host.cmd(8'hbc);
        u_host.cmd(8'h3f);
        @(posedge clock);
        check(32'({prechargeTiedDesel, prechargeFullRef}), 32'h1);
        for (int m = 0; m < 4; m++) begin
            u_host.cmd(8'ha4 + 8'(m));
            @(posedge clock);
            check(32'({pixelForceOn, pixelForceOff, pixelInvert,
                       forcedGrayLevel}), 32'({m == 1, m == 2, m == 3,
                       (m == 1) ? 4'hf : 4'h0}));
        end
        // opcode-valued argument, data write in between
        u_host.cmd(8'ha8);
        u_host.wr(`ODCC_OFS_DATA, 8'haf);
        u_host.cmd(8'ha8);
        u_host.cmd(8'haf);
        @(posedge clock);
        check(32'({muxRatio, displayOn}), 32'({7'h28, 1'b1}));
        u_host.cmd(8'hb8);
        repeat (8) u_host.cmd(8'hae);
        u_host.cmd(8'h81);
        u_host.cmd(8'ha5);
        u_host.rd(`ODCC_OFS_MODE, d);
        check(32'({d[1:0], displayOn}), 32'({2'h3, 1'b1}));
        // writes off the command offset change nothing
        u_host.wr(`ODCC_OFS_MUX, 8'h11);
        u_host.rd(`ODCC_OFS_MUX, d);
        check(d, 32'h28);
        u_host.rd(8'h3c, d);
        check(d, 32'h0);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            u_host.rd(rows[i].ofs, d);
            case (rows[i].ofs)
                `ODCC_OFS_MUX:    check(d, 32'h4f);
                `ODCC_OFS_MASTER: check(d, 32'h3);
                `ODCC_OFS_DESEL:  check(d, 32'h11);
                `ODCC_OFS_PRECH:  check(d, 32'h18);
                `ODCC_OFS_PHASE:  check(d, 32'h53);
                `ODCC_OFS_ROWPER: check(d, 32'h25);
                default:          check(d, 32'h0);
            endcase
        end
        ports(32'b001100001);
        wrapUp();
    end
endmodule // tb_oled_display_config_commands
